// [dv/moisture_detect_control_tb.sv]
// Self-checking bench for the moisture detection control block
// Assumes mdc_top with APB registers; the bench plays the analog engine
`timescale 1ns/1ns
module moisture_detect_control_tb;
    // Short auto period keeps the run brief
    localparam int AUTO_N = 400;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic meas_done = 1'b0, meas_wet = 1'b0, moisture_present = 1'b1;
    logic [2:0] meas_result = 3'h0;
    logic [1:0] meas_cur = 2'h0;
    logic [7:0] meas_avg = 8'h00, meas_max = 8'h00, meas_min = 8'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, meas_start, rearm, irq, f;
    logic [1:0] test_current_sel, pc, ec;
    logic [7:0] wet_voltage_threshold, fv;
    logic [5:0] noise_margin;
    logic [2:0] averaging_count, measure_retry_count;
    int miscompares = 0, checks_done = 0, starts = 0, rearms = 0, gap = 0, last_gap = 0, s0, r0;

    mdc_top #(.AUTO_CYCLES(AUTO_N)) uut (
        .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .meas_start, .test_current_sel, .wet_voltage_threshold, .noise_margin, .averaging_count,
        .measure_retry_count, .meas_done, .meas_result, .meas_wet, .meas_cur, .meas_avg, .meas_max,
        .meas_min, .moisture_present, .rearm, .irq
    );

    initial begin
        forever #50 clock = ~clock;
    end

    // ****************
    // Event counters
    // ****************
    always @(posedge clock) begin
        gap <= (meas_start === 1'b1 || rst_n !== 1'b1) ? 0 : gap + 1;
        if (meas_start === 1'b1) begin
            starts <= starts + 1;
            last_gap <= gap;
        end
        if (rearm === 1'b1) begin
            rearms <= rearms + 1;
        end
    end

    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
        end
    endtask : apb

    // Returns mid-cycle so ports written at the completing edge have settled
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, rd);
        @(negedge clock);
    endtask : wr

    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask : rchk

    // Port values are taken when the task is called; only the compare waits for mid-cycle
    task automatic pchk(input logic [31:0] got, input logic [31:0] exp);
        @(negedge clock);
        chk(got, exp);
    endtask : pchk

    task automatic launch(input logic [31:0] v, input logic [31:0] exp, input int n);
        s0 = starts;
        wr(mdc_pkg::IDX_CTRL, v);
        rchk(mdc_pkg::IDX_CTRL, exp);
        chk(32'(starts - s0), 32'(n));
    endtask : launch

    // Raw results are valid only with the done pulse, garbage after it
    task automatic engine_done(input logic [2:0] res, input logic wet);
        @(posedge clock);
        meas_done <= 1'b1;
        meas_result <= res;
        meas_wet <= wet;
        meas_cur <= 2'h2;
        meas_avg <= 8'h5A;
        meas_max <= 8'h6B;
        meas_min <= 8'h4C;
        @(posedge clock);
        meas_done <= 1'b0;
        meas_cur <= 2'h1;
        meas_avg <= 8'hEE;
        meas_max <= 8'hEE;
        meas_min <= 8'hEE;
    endtask : engine_done

    task automatic wait_starts(input int n);
        int k;
        k = 0;
        while (starts < n && k < 2000) begin
            @(posedge clock);
            k++;
        end
        if (starts < n) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, starts, n);
        end
    endtask : wait_starts

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (10000) @(posedge clock);
        miscompares++;
        give_verdict();
    end

    // ****************
    // Tests
    // ****************
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rchk(mdc_pkg::IDX_NOISE, 32'h0000_0000);
        rchk(mdc_pkg::IDX_CUR_SEL, 32'h0000_0000);
        rchk(mdc_pkg::IDX_VTHR, 32'h0000_0077);
        rchk(mdc_pkg::IDX_CTRL, 32'h0000_0041);
        rchk(mdc_pkg::IDX_FINAL_CUR, 32'h0000_0000);
        rchk(mdc_pkg::IDX_AVG, 32'h0000_0000);
        rchk(mdc_pkg::IDX_MAX, 32'h0000_0000);
        rchk(mdc_pkg::IDX_MIN, 32'h0000_0000);
        pchk(32'(pslverr), 32'h0000_0000);
        rchk(mdc_pkg::IDX_MEAS_CFG, 32'h0000_0010);
        $display("test reset_values done");
        wait_starts(1);
        chk(32'(last_gap >= AUTO_N - 3 && last_gap <= AUTO_N + 3), 32'h0000_0001);
        engine_done(3'h0, 1'b0);
        wait_starts(2);
        chk(32'(last_gap >= AUTO_N - 3 && last_gap <= AUTO_N + 3), 32'h0000_0001);
        engine_done(3'h0, 1'b0);
        wr(mdc_pkg::IDX_CTRL, 32'h0000_0001);
        $display("test auto_period done");
        for (int i = 0; i < 4; i++) begin
            wr(mdc_pkg::IDX_CUR_SEL, 32'(i));
            rchk(mdc_pkg::IDX_CUR_SEL, 32'(i));
            pchk(32'(test_current_sel), 32'(i));
        end
        wr(mdc_pkg::IDX_VTHR, 32'h0000_00A5);
        rchk(mdc_pkg::IDX_VTHR, 32'h0000_00A5);
        pchk(32'(wet_voltage_threshold), 32'h0000_00A5);
        pchk(32'(noise_margin), 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            wr(mdc_pkg::IDX_MEAS_CFG, 32'(((7 - i) << 4) | i));
            pchk(32'(averaging_count), 32'(i));
            pchk(32'(measure_retry_count), 32'(7 - i));
        end
        wr(mdc_pkg::IDX_MEAS_CFG, 32'h0000_0010);
        $display("test config_fields done");
        pc = 2'h2;
        wr(mdc_pkg::IDX_IRQ_EN, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            launch(32'h0000_0011, 32'h0000_0011, 1);
            rchk(mdc_pkg::IDX_FINAL_CUR, {30'h0, pc});
            engine_done(3'(i), 1'b0);
            f = (i >= 1 && i <= 3);
            fv = (i == 3) ? 8'hFF : 8'h00;
            ec = (i == 1 || i == 3) ? 2'h0 : ((i == 4) ? 2'h3 : 2'h2);
            rchk(mdc_pkg::IDX_FINAL_CUR, {30'h0, ec});
            rchk(mdc_pkg::IDX_AVG, {24'h0, f ? fv : 8'h5A});
            rchk(mdc_pkg::IDX_MAX, {24'h0, f ? fv : 8'h6B});
            rchk(mdc_pkg::IDX_MIN, {24'h0, f ? fv : 8'h4C});
            rchk(mdc_pkg::IDX_CTRL, 32'h0000_0001);
            pc = ec;
        end
        $display("test outcomes done");
        pchk(32'(irq), 32'h0000_0001);
        wr(mdc_pkg::IDX_IRQ_EN, 32'h0000_0000);
        pchk(32'(irq), 32'h0000_0000);
        wr(mdc_pkg::IDX_IRQ_EN, 32'h0000_0001);
        pchk(32'(irq), 32'h0000_0001);
        rchk(mdc_pkg::IDX_IRQ_STAT, 32'h0000_0001);
        wr(mdc_pkg::IDX_IRQ_CLR, 32'h0000_0001);
        pchk(32'(irq), 32'h0000_0000);
        rchk(mdc_pkg::IDX_IRQ_STAT, 32'h0000_0000);
        wr(mdc_pkg::IDX_FINAL_CUR, 32'h0000_00FF);
        rchk(mdc_pkg::IDX_FINAL_CUR, {30'h0, pc});
        wr(8'h90, 32'h0000_00FF);
        rchk(8'h90, 32'h0000_0000);
        $display("test irq_and_access done");
        // Retry must be refused until moisture has been seen
        launch(32'h0000_0005, 32'h0000_0001, 0);
        launch(32'h0000_0011, 32'h0000_0011, 1);
        engine_done(3'h0, 1'b1);
        launch(32'h0000_0005, 32'h0000_0005, 1);
        engine_done(3'h0, 1'b1);
        rchk(mdc_pkg::IDX_CTRL, 32'h0000_0001);
        r0 = rearms;
        @(posedge clock);
        moisture_present <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'(rearms - r0), 32'h0000_0001);
        @(posedge clock);
        moisture_present <= 1'b1;
        launch(32'h0000_0010, 32'h0000_0010, 1);
        engine_done(3'h0, 1'b1);
        r0 = rearms;
        @(posedge clock);
        moisture_present <= 1'b0;
        repeat (4) @(posedge clock);
        chk(32'(rearms - r0), 32'h0000_0000);
        rchk(mdc_pkg::IDX_STATUS, 32'h0000_0002);
        rchk(mdc_pkg::IDX_IRQ_STAT, 32'h0000_0007);
        $display("test retry_rearm done");
        give_verdict();
    end
endmodule : moisture_detect_control_tb

// [src/mdc_pkg.sv]
// Constants for the moisture detection control block
// Assumes an APB slave with 32-bit data and a 10 MHz clock
// Overview of operation
// [RULE1] Software leaves noise margin at reset value
// [RULE2] Two-bit selector picks the test current
// [RULE3] Eight-bit voltage threshold, resets to 0x77
// [RULE4] Auto detection runs every 16 s
// [RULE5] Manual request bit runs, self-clears
// [RULE6] Retry only after moisture was found
// [RULE7] Auto re-arm once moisture disappears
// [RULE8] Final current forced on abort, open, short
// [RULE9] Readings forced on abort, ground, open
// [RULE10] Averaging code selects one to 128 samples
// [RULE11] Clamp persisting after retries gives abort
// [RULE12] Results update together only on completion
package mdc_pkg;
    // Register indices; printed offsets are not word multiples
    localparam logic [7:0] IDX_NOISE = 8'h73;
    localparam logic [7:0] IDX_CUR_SEL = 8'h74;
    localparam logic [7:0] IDX_VTHR = 8'h75;
    localparam logic [7:0] IDX_CTRL = 8'h76;
    localparam logic [7:0] IDX_FINAL_CUR = 8'h77;
    localparam logic [7:0] IDX_AVG = 8'h78;
    localparam logic [7:0] IDX_MAX = 8'h79;
    localparam logic [7:0] IDX_MIN = 8'h7A;
    localparam logic [7:0] IDX_MEAS_CFG = 8'h80;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h81;
    localparam logic [7:0] IDX_IRQ_EN = 8'h82;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h83;
    localparam logic [7:0] IDX_STATUS = 8'h84;
    localparam int ADDR_SHIFT = 2;
    // Reset values
    localparam logic [5:0] NOISE_RST = 6'h00;
    localparam logic [1:0] CUR_SEL_RST = 2'h0;
    localparam logic [7:0] VTHR_RST = 8'h77;
    localparam logic [2:0] RETRY_RST = 3'h1;
    localparam logic [2:0] AVG_RST = 3'h0;
    // Control register bit positions
    localparam int CTRL_AUTO_BIT = 6;
    localparam int CTRL_MAN_BIT = 4;
    localparam int CTRL_RTY_BIT = 2;
    localparam int CTRL_REARM_BIT = 0;
    // Measurement config fields
    localparam int CFG_AVG_LSB = 0;
    localparam int CFG_RTY_LSB = 4;
    // Outcomes reported by the analog front end
    typedef enum logic [2:0] {MDC_RES_OK, MDC_RES_ABORT, MDC_RES_GROUND, MDC_RES_OPEN,
                              MDC_RES_SHORT} mdc_result_t;
    localparam logic [1:0] CUR_LOWEST = 2'h0;
    localparam logic [1:0] CUR_HIGHEST = 2'h3;
    localparam logic [7:0] READ_LOW = 8'h00;
    localparam logic [7:0] READ_HIGH = 8'hFF;
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_WET = 1;
    localparam int IRQ_DRY = 2;
    localparam int IRQ_W = 3;
    // Timing
    localparam longint CLK_HZ = 10000000;
    localparam longint AUTO_PERIOD_S = 16;
    localparam longint AUTO_CYCLES = AUTO_PERIOD_S * CLK_HZ;
    localparam logic [31:0] PSLVERR_NONE = 32'h0000_0000;
endpackage : mdc_pkg

// [src/mdc_result_mem.sv]
// Result store: four bytes of final results, registered read
// Assumes one writer that updates all words together
`timescale 1ns/1ns
module mdc_result_mem (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [1:0] wr_cur,
    input wire logic [7:0] wr_avg,
    input wire logic [7:0] wr_max,
    input wire logic [7:0] wr_min,
    input wire logic [1:0] rd_sel,
    output logic [7:0] rd_data
);
    logic [7:0] mem_reg [4];
    logic [7:0] mem_next [4];
    logic [7:0] rd_reg;
    logic [7:0] rd_next;
    always_comb begin
        mem_next = mem_reg;
        if (wr_en) begin // RULE12
            mem_next[0] = {6'h00, wr_cur};
            mem_next[1] = wr_avg;
            mem_next[2] = wr_max;
            mem_next[3] = wr_min;
        end
        rd_next = mem_reg[rd_sel];
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mem_reg <= '{default: 8'h00};
            rd_reg <= 8'h00;
        end else begin
            mem_reg <= mem_next;
            rd_reg <= rd_next;
        end
    end
    assign rd_data = rd_reg;
endmodule : mdc_result_mem

// [src/mdc_top.sv]
// Moisture detection control: registers, launch sequencing, results
// Assumes an analog engine that runs one measurement per start pulse
`timescale 1ns/1ns
module mdc_top #(
    parameter longint AUTO_CYCLES = mdc_pkg::AUTO_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic meas_start,
    output logic [1:0] test_current_sel,
    output logic [7:0] wet_voltage_threshold,
    output logic [5:0] noise_margin,
    output logic [2:0] averaging_count,
    output logic [2:0] measure_retry_count,
    input wire logic meas_done,
    input wire logic [2:0] meas_result,
    input wire logic meas_wet,
    input wire logic [1:0] meas_cur,
    input wire logic [7:0] meas_avg,
    input wire logic [7:0] meas_max,
    input wire logic [7:0] meas_min,
    input wire logic moisture_present,
    output logic rearm,
    output logic irq
);
    // ****************************************
    // Register file
    // ****************************************
    typedef enum logic [1:0] {MDC_IDLE, MDC_RUN} mdc_state_t;
    logic [5:0] noise_reg, noise_next;
    logic [1:0] cur_reg, cur_next;
    logic [7:0] vthr_reg, vthr_next;
    logic auto_reg, auto_next, man_reg, man_next, rty_reg, rty_next, rearm_en_reg, rearm_en_next;
    logic [2:0] avg_reg, avg_next, rcnt_reg, rcnt_next;
    logic [mdc_pkg::IRQ_W-1:0] ist_reg, ist_next, ien_reg, ien_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic found_reg, found_next;
    logic [27:0] tmr_reg, tmr_next;
    mdc_state_t st_reg, st_next;
    logic start_reg, start_next, rearm_reg, rearm_next, irq_reg, irq_next;
    logic [7:0] idx;
    logic wr, rd_res;
    logic [7:0] res_data;
    logic auto_fire;
    logic [1:0] f_cur;
    logic [7:0] f_avg, f_max, f_min;

    function automatic logic [7:0] to_idx(input logic [11:0] a);
        to_idx = a[9:2];
    endfunction : to_idx

    assign idx = to_idx(paddr);
    // Commit on the completing edge, so a write lands exactly when pready is seen
    assign wr = psel && penable && pwrite && pready_reg;
    assign rd_res = idx >= mdc_pkg::IDX_FINAL_CUR && idx <= mdc_pkg::IDX_MIN;
    assign auto_fire = auto_reg && (tmr_reg == 28'(AUTO_CYCLES - 1));

    // ****************************************
    // Forced outcome values
    // ****************************************
    always_comb begin
        f_cur = meas_cur;
        f_avg = meas_avg;
        f_max = meas_max;
        f_min = meas_min;
        if (meas_result == mdc_pkg::MDC_RES_ABORT || meas_result == mdc_pkg::MDC_RES_OPEN) begin
            f_cur = mdc_pkg::CUR_LOWEST; // RULE8
        end else if (meas_result == mdc_pkg::MDC_RES_SHORT) begin
            f_cur = mdc_pkg::CUR_HIGHEST; // RULE8
        end
        if (meas_result == mdc_pkg::MDC_RES_ABORT || meas_result == mdc_pkg::MDC_RES_GROUND) begin
            f_avg = mdc_pkg::READ_LOW; // RULE9 RULE11
            f_max = mdc_pkg::READ_LOW;
            f_min = mdc_pkg::READ_LOW;
        end else if (meas_result == mdc_pkg::MDC_RES_OPEN) begin
            f_avg = mdc_pkg::READ_HIGH; // RULE9
            f_max = mdc_pkg::READ_HIGH;
            f_min = mdc_pkg::READ_HIGH;
        end
    end

    mdc_result_mem u_res (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(meas_done && st_reg == MDC_RUN),
        .wr_cur(f_cur),
        .wr_avg(f_avg),
        .wr_max(f_max),
        .wr_min(f_min),
        .rd_sel(2'(idx - mdc_pkg::IDX_FINAL_CUR)),
        .rd_data(res_data)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        noise_next = noise_reg;
        cur_next = cur_reg;
        vthr_next = vthr_reg;
        auto_next = auto_reg;
        man_next = man_reg;
        rty_next = rty_reg;
        rearm_en_next = rearm_en_reg;
        avg_next = avg_reg;
        rcnt_next = rcnt_reg;
        ien_next = ien_reg;
        ist_next = ist_reg;
        found_next = found_reg;
        st_next = st_reg;
        start_next = 1'b0;
        rearm_next = 1'b0;
        tmr_next = auto_reg ? (auto_fire ? 28'h0000000 : tmr_reg + 28'h0000001) : 28'h0000000; // RULE4
        pready_next = psel && penable && !pready_reg;
        prdata_next = prdata_reg;
        if (wr) begin
            if (idx == mdc_pkg::IDX_NOISE) begin
                noise_next = pwdata[5:0]; // RULE1
            end else if (idx == mdc_pkg::IDX_CUR_SEL) begin
                cur_next = pwdata[1:0]; // RULE2
            end else if (idx == mdc_pkg::IDX_VTHR) begin
                vthr_next = pwdata[7:0]; // RULE3
            end else if (idx == mdc_pkg::IDX_CTRL) begin
                auto_next = pwdata[mdc_pkg::CTRL_AUTO_BIT];
                rearm_en_next = pwdata[mdc_pkg::CTRL_REARM_BIT];
                man_next = man_reg | pwdata[mdc_pkg::CTRL_MAN_BIT]; // RULE5
                rty_next = rty_reg | (pwdata[mdc_pkg::CTRL_RTY_BIT] & found_reg); // RULE6
            end else if (idx == mdc_pkg::IDX_MEAS_CFG) begin
                avg_next = pwdata[mdc_pkg::CFG_AVG_LSB +: 3]; // RULE10
                rcnt_next = pwdata[mdc_pkg::CFG_RTY_LSB +: 3]; // RULE11
            end else if (idx == mdc_pkg::IDX_IRQ_EN) begin
                ien_next = pwdata[mdc_pkg::IRQ_W-1:0];
            end else if (idx == mdc_pkg::IDX_IRQ_CLR) begin
                ist_next = ist_reg & ~pwdata[mdc_pkg::IRQ_W-1:0];
            end
        end
        case (st_reg)
            MDC_IDLE: begin
                if (man_next || rty_next || auto_fire) begin
                    start_next = 1'b1; // RULE4 RULE5 RULE6
                    st_next = MDC_RUN;
                end
            end
            MDC_RUN: begin
                if (meas_done) begin
                    st_next = MDC_IDLE;
                    man_next = 1'b0; // RULE5
                    rty_next = 1'b0; // RULE6
                    found_next = meas_wet;
                    ist_next[mdc_pkg::IRQ_DONE] = 1'b1;
                    if (meas_wet) begin
                        ist_next[mdc_pkg::IRQ_WET] = 1'b1;
                    end
                end
            end
            default: st_next = MDC_IDLE;
        endcase
        if (found_reg && !moisture_present && rearm_en_reg && st_reg == MDC_IDLE) begin
            found_next = 1'b0; // RULE7
            rearm_next = 1'b1;
            ist_next[mdc_pkg::IRQ_DRY] = 1'b1;
        end
        irq_next = |(ist_next & ien_next);
        if (psel && !penable && !pwrite) begin
            prdata_next = 32'h0000_0000;
            if (idx == mdc_pkg::IDX_NOISE) begin
                prdata_next[5:0] = noise_reg;
            end else if (idx == mdc_pkg::IDX_CUR_SEL) begin
                prdata_next[1:0] = cur_reg;
            end else if (idx == mdc_pkg::IDX_VTHR) begin
                prdata_next[7:0] = vthr_reg;
            end else if (idx == mdc_pkg::IDX_CTRL) begin
                prdata_next[mdc_pkg::CTRL_AUTO_BIT] = auto_reg;
                prdata_next[mdc_pkg::CTRL_MAN_BIT] = man_reg;
                prdata_next[mdc_pkg::CTRL_RTY_BIT] = rty_reg;
                prdata_next[mdc_pkg::CTRL_REARM_BIT] = rearm_en_reg;
            end else if (idx == mdc_pkg::IDX_MEAS_CFG) begin
                prdata_next[mdc_pkg::CFG_AVG_LSB +: 3] = avg_reg;
                prdata_next[mdc_pkg::CFG_RTY_LSB +: 3] = rcnt_reg;
            end else if (idx == mdc_pkg::IDX_IRQ_STAT) begin
                prdata_next[mdc_pkg::IRQ_W-1:0] = ist_reg;
            end else if (idx == mdc_pkg::IDX_IRQ_EN) begin
                prdata_next[mdc_pkg::IRQ_W-1:0] = ien_reg;
            end else if (idx == mdc_pkg::IDX_STATUS) begin
                prdata_next[1:0] = {found_reg, st_reg == MDC_RUN};
            end
        end else if (psel && penable && !pwrite && !pready_reg && rd_res) begin
            // Result store answers one cycle later through its own register
            prdata_next = {24'h000000, res_data};
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            noise_reg <= mdc_pkg::NOISE_RST;
            cur_reg <= mdc_pkg::CUR_SEL_RST;
            vthr_reg <= mdc_pkg::VTHR_RST;
            auto_reg <= 1'b1;
            man_reg <= 1'b0;
            rty_reg <= 1'b0;
            rearm_en_reg <= 1'b1;
            avg_reg <= mdc_pkg::AVG_RST;
            rcnt_reg <= mdc_pkg::RETRY_RST;
            ist_reg <= '0;
            ien_reg <= '0;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            found_reg <= 1'b0;
            tmr_reg <= 28'h0000000;
            st_reg <= MDC_IDLE;
            start_reg <= 1'b0;
            rearm_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            noise_reg <= noise_next;
            cur_reg <= cur_next;
            vthr_reg <= vthr_next;
            auto_reg <= auto_next;
            man_reg <= man_next;
            rty_reg <= rty_next;
            rearm_en_reg <= rearm_en_next;
            avg_reg <= avg_next;
            rcnt_reg <= rcnt_next;
            ist_reg <= ist_next;
            ien_reg <= ien_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            found_reg <= found_next;
            tmr_reg <= tmr_next;
            st_reg <= st_next;
            start_reg <= start_next;
            rearm_reg <= rearm_next;
            irq_reg <= irq_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = mdc_pkg::PSLVERR_NONE[0];
    assign meas_start = start_reg;
    assign test_current_sel = cur_reg;
    assign wet_voltage_threshold = vthr_reg;
    assign noise_margin = noise_reg;
    assign averaging_count = avg_reg;
    assign measure_retry_count = rcnt_reg;
    assign rearm = rearm_reg;
    assign irq = irq_reg;

    // ****************************************
    // Checks
    // ****************************************
    chk_start_run: assert property (@(posedge clock) disable iff (!rst_n)
        meas_start |-> st_reg == MDC_RUN) else $error("start without run"); // RULE5
    chk_man_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (st_reg == MDC_RUN && meas_done) |=> !man_reg) else $error("manual bit stuck"); // RULE5
    chk_retry_gate: assert property (@(posedge clock) disable iff (!rst_n)
        (!rty_reg && !found_reg && st_reg == MDC_IDLE) |=> !rty_reg) else $error("retry without moisture"); // RULE6
    chk_rearm_dry: assert property (@(posedge clock) disable iff (!rst_n)
        rearm |-> !found_reg && $past(found_reg)) else $error("rearm without found"); // RULE7
    chk_vthr_reset: assert property (@(posedge clock)
        !rst_n |=> wet_voltage_threshold == mdc_pkg::VTHR_RST) else $error("threshold reset"); // RULE3
    chk_cur_write: assert property (@(posedge clock) disable iff (!rst_n)
        (wr && idx == mdc_pkg::IDX_CUR_SEL) |=> test_current_sel == $past(pwdata[1:0])) else $error("sel"); // RULE2
    chk_auto_off: assert property (@(posedge clock) disable iff (!rst_n)
        !auto_reg |=> tmr_reg == 28'h0000000) else $error("timer runs"); // RULE4
    chk_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(irq) |-> |(ist_reg & ien_reg)) else $error("irq without cause");
    cov_manual: cover property (@(posedge clock) disable iff (!rst_n) man_reg ##[1:50] !man_reg);
    cov_wet: cover property (@(posedge clock) disable iff (!rst_n) $rose(found_reg));
    cov_rearm: cover property (@(posedge clock) disable iff (!rst_n) rearm);
endmodule : mdc_top
